// ### hw/classifier_action_frame_pointer.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cl_action_defines.svh"

module classifier_action_frame_pointer
    import cl_action_pkg::*;
(
    input  wire logic        sys_clk,                // core clock
    input  wire logic        rst,                    // async reset, high
    input  wire logic        frame_start,            // load context of a new frame
    input  wire logic [7:0]  start_pointer,          // initial pointer of the frame
    input  wire logic [1:0]  start_layer,            // initial layer at pointer
    input  wire logic [1:0]  vlan_tag_count,         // vlan tags at pointer
    input  wire logic [3:0]  ip_version,             // ip version nibble at link payload
    input  wire logic [3:0]  ipv4_hdr_words,         // ipv4 header length in words
    input  wire logic [1:0]  lookup_index,           // lookup that produced the action
    input  wire logic        action_valid,           // action result present
    input  wire logic        reduced_action,         // short point field is used
    input  wire logic [2:0]  short_pipe_point,       // reduced point code
    input  wire logic [4:0]  pipe_point_select,      // full point code
    input  wire logic [1:0]  pipe_force_control,     // forcing mode
    input  wire logic        pipe_action_variant,    // variant select
    input  wire logic [3:0]  following_key_kind,     // next key kind
    input  wire logic [1:0]  quad_byte_advance,      // 4-byte units
    input  wire logic [4:0]  double_byte_advance,    // 2-byte units
    input  wire logic [1:0]  layer_skip_code,        // protocol layer skip
    input  wire logic [1:0]  layer_at_pointer,       // new layer value
    input  wire logic        strip_leading_bytes,    // normalize request
    input  wire logic [7:0]  reg_addr,               // register byte address
    input  wire logic [31:0] reg_wdata,              // register write data
    input  wire logic        reg_wr,                 // write strobe
    input  wire logic        reg_rd,                 // read strobe
    output logic [31:0]      reg_rdata,              // read data, cycle after strobe
    output logic             action_ready,           // action may be taken
    output logic [7:0]       frame_pointer,          // current frame pointer
    output logic [1:0]       current_layer,          // layer at pointer
    output logic [3:0]       key_kind,               // key kind for next lookup
    output logic             key_triple_indexed,     // indexed triple-vlan key
    output logic             key_dst_info,           // destination fields into source slots
    output logic             clm_done,               // no more lookups for frame
    output logic             pipe_forced,            // pipeline point was forced
    output logic [4:0]       pipe_point,             // forced point
    output logic [2:0]       pipe_act,               // forced pipeline action
    output logic             strip_valid,            // strip order pulse
    output logic [5:0]       strip_count,            // bytes to strip
    output logic             key_go                  // updates done, next key may start
);

    // ----------------------------------------------------------------
    // latched action
    // ----------------------------------------------------------------
    action_state_t state;
    logic          take;
    logic          act_reduced;
    logic [2:0]    act_short;
    logic [4:0]    act_point;
    logic [1:0]    act_force;
    logic          act_variant;
    logic [3:0]    act_key;
    logic [1:0]    act_quad;
    logic [4:0]    act_dbl;
    logic [1:0]    act_skip;
    logic [1:0]    act_layer;
    logic          act_strip;
    logic [1:0]    act_lookup;
    logic [1:0]    ctx_vlan;
    logic [3:0]    ctx_ipver;
    logic [3:0]    ctx_ihl;
    logic          moved;
    logic [2:0]    tri_vid_sel;
    logic [1:0]    err_flags;
    logic [7:0]    skip_bytes;
    logic [7:0]    ip_bytes;
    logic [7:0]    word_bytes;
    logic [4:0]    mapped_point;

    assign take = action_valid && action_ready && !frame_start;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            act_reduced <= 1'b0;
            act_short   <= 3'h0;
            act_point   <= 5'h00;
            act_force   <= 2'h0;
            act_variant <= 1'b0;
            act_key     <= 4'h0;
            act_quad    <= 2'h0;
            act_dbl     <= 5'h00;
            act_skip    <= 2'h0;
            act_layer   <= 2'h0;
            act_strip   <= 1'b0;
            act_lookup  <= 2'h0;
            ctx_vlan    <= 2'h0;
            ctx_ipver   <= 4'h0;
            ctx_ihl     <= 4'h0;
        end else if (take) begin
            act_reduced <= reduced_action;
            act_short   <= short_pipe_point;
            act_point   <= pipe_point_select;
            act_force   <= pipe_force_control;
            act_variant <= pipe_action_variant;
            act_key     <= following_key_kind;
            act_quad    <= quad_byte_advance;
            act_dbl     <= double_byte_advance;
            act_skip    <= layer_skip_code;
            act_layer   <= layer_at_pointer;
            act_strip   <= strip_leading_bytes;
            act_lookup  <= lookup_index;
            ctx_vlan    <= vlan_tag_count;
            ctx_ipver   <= ip_version;
            ctx_ihl     <= ipv4_hdr_words;
        end
    end

    // ----------------------------------------------------------------
    // sequencer: skip, then advance, then strip
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state        <= ST_IDLE;
            action_ready <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    action_ready <= !take;
                    if (take) begin
                        state <= ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    state <= ST_ADVANCE; // [RQ9]
                end
                ST_ADVANCE: begin
                    state <= ST_STRIP; // [RQ15]
                end
                ST_STRIP: begin
                    state        <= ST_IDLE; // [RQ18]
                    action_ready <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pointer arithmetic
    // ----------------------------------------------------------------
    always_comb begin
        ip_bytes = (ctx_ipver == 4'h6) ? `IPV6_HDR_BYTES : {2'h0, ctx_ihl, 2'h0}; // [RQ11]
        skip_bytes = 8'h00; // [RQ10]
        if (act_skip == `SKIP_LINK && current_layer == LAYER_ETH) begin
            skip_bytes = `MAC_PAIR_BYTES + {4'h0, ctx_vlan, 2'h0}; // [RQ10]
        end else if (act_skip == `SKIP_NET_LINK) begin
            if (current_layer == LAYER_ETH) begin
                skip_bytes = `MAC_PAIR_BYTES + {4'h0, ctx_vlan, 2'h0} + ip_bytes; // [RQ11]
            end else if (current_layer == LAYER_CW
                         && (ctx_ipver == 4'h4 || ctx_ipver == 4'h6)) begin
                skip_bytes = ip_bytes; // [RQ11]
            end
        end
        // labels skipped upstream are already behind the pointer
        word_bytes = {4'h0, act_quad, 2'h0} + {2'h0, act_dbl, 1'b0}; // [RQ6] [RQ7] [RQ8]
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_pointer <= 8'h00;
            moved         <= 1'b0;
        end else if (frame_start && state == ST_IDLE) begin
            frame_pointer <= start_pointer;
        end else if (state == ST_SKIP) begin
            frame_pointer <= frame_pointer + skip_bytes; // [RQ9]
            moved         <= (skip_bytes != 8'h00);
        end else if (state == ST_ADVANCE) begin
            frame_pointer <= frame_pointer + word_bytes; // [RQ6] [RQ7] [RQ9]
            moved         <= moved || (word_bytes != 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // layer type and next key
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            current_layer <= LAYER_ETH;
        end else if (frame_start && state == ST_IDLE) begin
            current_layer <= start_layer;
        end else if (state == ST_ADVANCE) begin
            if (moved || word_bytes != 8'h00
                || (current_layer == LAYER_DATA && act_key != `KEY_DEFAULT)) begin
                current_layer <= act_layer; // [RQ12] [RQ13]
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            key_kind           <= `KEY_DEFAULT;
            key_triple_indexed <= 1'b0;
            key_dst_info       <= 1'b0;
            clm_done           <= 1'b0;
        end else if (frame_start && state == ST_IDLE) begin
            key_kind           <= `KEY_DEFAULT;
            key_triple_indexed <= 1'b0;
            key_dst_info       <= 1'b0;
            clm_done           <= 1'b0;
        end else if (state == ST_ADVANCE) begin
            key_kind           <= act_key; // [RQ2] [RQ3] [RQ5]
            key_triple_indexed <= (act_key == `KEY_TRI_VID) && tri_vid_sel[act_lookup]; // [RQ3]
            key_dst_info       <= (act_key == `KEY_NORMAL_DST); // [RQ4]
            if (act_key == `KEY_CLM_DONE) begin
                clm_done <= 1'b1; // [RQ5]
            end
        end
    end

    // ----------------------------------------------------------------
    // forced pipeline point
    // ----------------------------------------------------------------
    always_comb begin
        unique case (act_short)
            3'h0:    mapped_point = `PT_CLM;
            3'h1:    mapped_point = `PT_OU_MIP;
            3'h2:    mapped_point = `PT_IN_MIP;
            3'h3:    mapped_point = `PT_PORT_VOE;
            3'h4:    mapped_point = `PT_OU_VOE;
            3'h5:    mapped_point = `PT_IN_VOE;
            3'h6:    mapped_point = `PT_REW_IN_VOE;
            3'h7:    mapped_point = `PT_REW_OU_VOE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pipe_forced <= 1'b0;
            pipe_point  <= 5'h00;
            pipe_act    <= PACT_NONE;
        end else if (frame_start && state == ST_IDLE) begin
            pipe_forced <= 1'b0;
        end else if (state == ST_ADVANCE && act_force != `FORCE_NONE) begin
            pipe_forced <= 1'b1; // [RQ17]
            pipe_point  <= act_reduced ? mapped_point : act_point; // [RQ1]
            if (act_force == `FORCE_XTR) begin
                pipe_act <= PACT_XTR; // [RQ17]
            end else if (act_force == `FORCE_INJ) begin
                pipe_act <= act_variant ? PACT_INJ_MASQ : PACT_INJ; // [RQ17]
            end else begin
                pipe_act <= act_variant ? PACT_LBK_ASM : PACT_LBK_QS; // [RQ17]
            end
        end
    end

    // ----------------------------------------------------------------
    // strip order to rewriter and completion
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strip_valid <= 1'b0;
            strip_count <= 6'h00;
            key_go      <= 1'b0;
        end else begin
            strip_valid <= (state == ST_STRIP) && act_strip; // [RQ14] [RQ15]
            key_go      <= (state == ST_STRIP); // [RQ18]
            if (state == ST_STRIP && act_strip) begin
                strip_count <= (frame_pointer > `MAX_STRIP_BYTES)
                             ? 6'(`MAX_STRIP_BYTES) : frame_pointer[5:0]; // [RQ16]
            end
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tri_vid_sel <= `CTRL_RESET;
        end else if (reg_wr && reg_addr == `REG_CTRL) begin
            tri_vid_sel <= reg_wdata[2:0];
        end
    end

    // hardware set wins over a write-one clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            err_flags <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == `REG_ERROR) begin
                err_flags <= err_flags & ~reg_wdata[1:0];
            end
            if (state == ST_STRIP && act_strip && frame_pointer > `MAX_STRIP_BYTES) begin
                err_flags[`ERR_TOO_DEEP] <= 1'b1; // [RQ16]
            end
            if (state == ST_SKIP && act_skip == 2'h3) begin
                err_flags[`ERR_RSV_SKIP] <= 1'b1; // [RQ11]
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `REG_CTRL:   reg_rdata <= {29'h0, tri_vid_sel};
                `REG_STATUS: reg_rdata <= {14'h0, (state != ST_IDLE), clm_done,
                                           key_kind, 2'h0, current_layer, frame_pointer};
                `REG_ERROR:  reg_rdata <= {30'h0, err_flags};
                default:     reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_skip_none;
        @(posedge sys_clk) disable iff (rst)
        state == ST_SKIP && act_skip == `SKIP_NONE |=> $stable(frame_pointer);
    endproperty
    a_skip_none: assert property (p_skip_none) else $error("pointer moved on skip none"); // [RQ10]

    property p_eth_skip;
        @(posedge sys_clk) disable iff (rst)
        state == ST_SKIP && act_skip == `SKIP_LINK && current_layer == LAYER_ETH
        |=> frame_pointer == 8'($past(frame_pointer) + 8'd12 + {4'h0, ctx_vlan, 2'h0});
    endproperty
    a_eth_skip: assert property (p_eth_skip) else $error("link skip distance wrong"); // [RQ10]

    property p_word_adv;
        @(posedge sys_clk) disable iff (rst)
        state == ST_ADVANCE |=> frame_pointer
            == 8'($past(frame_pointer) + 8'(act_quad) * 8'd4 + 8'(act_dbl) * 8'd2);
    endproperty
    a_word_adv: assert property (p_word_adv) else $error("word offset add wrong"); // [RQ6] [RQ7]

    property p_layer_keep;
        @(posedge sys_clk) disable iff (rst)
        state == ST_ADVANCE && !moved && act_quad == 2'h0 && act_dbl == 5'h00
        && !(current_layer == LAYER_DATA && act_key != 4'h0) |=> $stable(current_layer);
    endproperty
    a_layer_keep: assert property (p_layer_keep) else $error("layer changed without cause"); // [RQ12]

    property p_strip_after_ptr;
        @(posedge sys_clk) disable iff (rst)
        strip_valid |-> $past(state, 2) == ST_ADVANCE && $stable(frame_pointer);
    endproperty
    a_strip_after_ptr: assert property (p_strip_after_ptr) else $error("strip before pointer"); // [RQ15]

    property p_strip_cap;
        @(posedge sys_clk) disable iff (rst)
        strip_valid |-> strip_count <= 6'd42;
    endproperty
    a_strip_cap: assert property (p_strip_cap) else $error("strip deeper than 42"); // [RQ16]

    property p_key_after_take;
        @(posedge sys_clk) disable iff (rst)
        take |=> !key_go [*3] ##1 key_go;
    endproperty
    a_key_after_take: assert property (p_key_after_take) else $error("key go not 4 cycles on"); // [RQ18]

    property p_done_sets;
        @(posedge sys_clk) disable iff (rst)
        key_go && key_kind == 4'hf |-> clm_done;
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done code did not end lookups"); // [RQ5]

    property p_pipe_keep;
        @(posedge sys_clk) disable iff (rst)
        state == ST_ADVANCE && act_force == 2'h0 |=> $stable(pipe_point) && $stable(pipe_act);
    endproperty
    a_pipe_keep: assert property (p_pipe_keep) else $error("pipe changed with force off"); // [RQ17]

endmodule

`default_nettype wire

// ### hw/cl_action_defines.svh
// How it works
// (RQ1) forced pipeline point comes from 3-bit short or 5-bit full field
// (RQ2) 4-bit following key kind forces next key; zero keeps default selection
// (RQ3) codes 1-7 pick label, stack, triple-vlan (per-lookup variant), full, normal keys
// (RQ4) code 8 builds normal key with destination mac and ipv4 destination
// (RQ5) code 15 ends classification; codes 9-14 pick tuple and custom keys
// (RQ6) pointer advances by 2-bit quad byte field times four bytes
// (RQ7) pointer advances by 5-bit double byte field times two bytes
// (RQ8) labels already skipped upstream are not added again by offsets
// (RQ9) layer skip moves pointer first, then word offsets are added
// (RQ10) skip code 0 stays; code 1 skips macs and 0-3 vlan tags
// (RQ11) code 2 also skips ip header with options; control word skips ip only
// (RQ12) layer type replaced only if pointer moved or raw data with key set
// (RQ13) layer codes: 0 ethernet, 1 ip/cw/ach, 2 mpls, 3 raw data
// (RQ14) strip bit tells rewriter to drop bytes ahead of the pointer
// (RQ15) pointer update completes before the strip instruction is issued
// (RQ16) strip depth never exceeds 42 bytes
// (RQ17) 2-bit force control: none, extract, inject, loopback; variant bit picks kind
// (RQ18) all updates land before the next lookup key is generated
`ifndef CL_ACTION_DEFINES_SVH
`define CL_ACTION_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_ERROR       8'h08
`define CTRL_RESET      3'h0
`define ERR_TOO_DEEP    0
`define ERR_RSV_SKIP    1

// ----------------------------------------------------------------
// field values
// ----------------------------------------------------------------
`define KEY_DEFAULT     4'h0
`define KEY_TRI_VID     4'h5
`define KEY_NORMAL_DST  4'h8
`define KEY_CLM_DONE    4'hf
`define SKIP_NONE       2'h0
`define SKIP_LINK       2'h1
`define SKIP_NET_LINK   2'h2
`define FORCE_NONE      2'h0
`define FORCE_XTR       2'h1
`define FORCE_INJ       2'h2

// ----------------------------------------------------------------
// full pipeline point codes
// ----------------------------------------------------------------
`define PT_PORT_VOE     5'h02
`define PT_CLM          5'h04
`define PT_OU_MIP       5'h06
`define PT_OU_VOE       5'h09
`define PT_IN_VOE       5'h0b
`define PT_IN_MIP       5'h0e
`define PT_REW_IN_VOE   5'h11
`define PT_REW_OU_VOE   5'h12

// ----------------------------------------------------------------
// byte counts
// ----------------------------------------------------------------
`define MAC_PAIR_BYTES  8'h0c
`define IPV6_HDR_BYTES  8'h28
`define MAX_STRIP_BYTES 8'h2a

`endif

// ### hw/cl_action_pkg.sv
package cl_action_pkg;
    typedef enum logic [1:0] {
        LAYER_ETH  = 2'h0,
        LAYER_CW   = 2'h1,
        LAYER_MPLS = 2'h2,
        LAYER_DATA = 2'h3
    } frame_layer_t;

    typedef enum logic [2:0] {
        PACT_NONE,
        PACT_XTR,
        PACT_INJ,
        PACT_INJ_MASQ,
        PACT_LBK_QS,
        PACT_LBK_ASM
    } pipe_act_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SKIP,
        ST_ADVANCE,
        ST_STRIP
    } action_state_t;
endpackage

// ### verification/rewriter_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// egress rewriter: keeps the depth of the last strip order
// ------------------------------------------------------------
module rewriter_model (
    input  wire logic       sys_clk,     // core clock
    input  wire logic       strip_valid, // strip order pulse
    input  wire logic [5:0] strip_count, // bytes to strip
    output logic      [5:0] last_strip   // depth of last order taken
);
    initial last_strip = 6'h00;
    // the order lives for one cycle only, so it is caught at that edge
    always @(posedge sys_clk) begin
        if (strip_valid) last_strip <= strip_count;
    end
endmodule

`default_nettype wire

// ### verification/classifier_action_frame_pointer_test.sv
`timescale 1ns/1ps
`default_nettype none

module classifier_action_frame_pointer_test;
    import cl_action_pkg::*;
    logic        sys_clk, rst, frame_start, action_valid, reduced_action, reg_wr, reg_rd;
    logic        pipe_action_variant, strip_leading_bytes, action_ready, key_triple_indexed;
    logic        key_dst_info, clm_done, pipe_forced, strip_valid, key_go;
    logic [7:0]  start_pointer, reg_addr, frame_pointer;
    logic [1:0]  start_layer, vlan_tag_count, lookup_index, pipe_force_control;
    logic [1:0]  quad_byte_advance, layer_skip_code, layer_at_pointer, current_layer;
    logic [3:0]  ip_version, ipv4_hdr_words, following_key_kind, key_kind;
    logic [2:0]  short_pipe_point, pipe_act;
    logic [4:0]  pipe_point_select, double_byte_advance, pipe_point;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0]  strip_count, last_strip;
    logic [7:0]  ptr;
    logic [1:0]  lay, err;
    logic [3:0]  kk;
    logic [2:0]  ctrl, pa;
    logic [4:0]  pt;
    logic        clm, forced;
    logic [4:0]  pmap [8] = '{5'h04, 5'h06, 5'h0e, 5'h02, 5'h09, 5'h0b, 5'h11, 5'h12};
    int          mismatches = 0;
    int          check_count = 0;

    classifier_action_frame_pointer i_classifier_action_frame_pointer (.*);
    rewriter_model i_rewriter_model (.sys_clk(sys_clk), .strip_valid(strip_valid),
                                     .strip_count(strip_count), .last_strip(last_strip));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // bytes moved by the layer skip code for the context at the pointer
    function automatic logic [7:0] skip_of(input logic [1:0] code, l, vl, input logic [3:0] v, w);
        logic [7:0] ip;
        ip = (v == 4'h6) ? 8'h28 : {2'h0, w, 2'h0};
        if (l == 2'h0 && code == 2'h1) return 8'h0c + {4'h0, vl, 2'h0};
        if (l == 2'h0 && code == 2'h2) return 8'h0c + {4'h0, vl, 2'h0} + ip;
        if (l == 2'h1 && code == 2'h2 && (v == 4'h4 || v == 4'h6)) return ip;
        return 8'h00;
    endfunction

    task automatic frame_go;
        @(posedge sys_clk);
        {frame_start, start_pointer, start_layer} <= {1'b1, 8'($urandom_range(40)), 2'($urandom)};
        @(posedge sys_clk);
        frame_start <= 1'b0;
        #1 {ptr, lay, kk, clm, forced} = {start_pointer, start_layer, 6'h00};
        check("frame_pointer", frame_pointer, ptr);
        check("clm_done", clm_done, 1'b0);
    endtask

    task automatic act(input logic [1:0] skip);
        logic [7:0]  mv;
        logic [7:0]  off;
        logic [31:0] d;
        logic        rdy;
        int          n;
        @(posedge sys_clk);
        {reduced_action, short_pipe_point, pipe_action_variant} <= 5'($urandom);
        {pipe_force_control, following_key_kind, quad_byte_advance} <= 8'($urandom);
        {double_byte_advance, layer_at_pointer, strip_leading_bytes} <= 8'($urandom);
        {vlan_tag_count, lookup_index} <= {2'($urandom), 2'($urandom_range(2))};
        pipe_point_select <= 5'($urandom_range(16));
        ipv4_hdr_words <= 4'($urandom_range(15, 5));
        ip_version <= (lay == 2'h0 || $urandom_range(1)) ? ($urandom_range(1) ? 4'h4 : 4'h6) : 4'h5;
        {layer_skip_code, action_valid} <= {skip, 1'b1};
        #1;
        mv = skip_of(skip, lay, vlan_tag_count, ip_version, ipv4_hdr_words);
        off = {4'h0, quad_byte_advance, 2'h0} + {2'h0, double_byte_advance, 1'h0};
        if ((mv | off) != 8'h00 || (lay == 2'h3 && following_key_kind != 4'h0))
            lay = layer_at_pointer;
        ptr = ptr + mv + off;
        if (skip == 2'h3) err[1] = 1'b1;
        if (strip_leading_bytes && ptr > 8'h2a) err[0] = 1'b1;
        kk = following_key_kind;
        if (following_key_kind == 4'hf) clm = 1'b1;
        if (pipe_force_control != 2'h0) begin
            forced = 1'b1;
            pt = reduced_action ? pmap[short_pipe_point] : pipe_point_select;
            pa = (pipe_force_control == 2'h1) ? 3'h1 :
                 {pipe_force_control[0], ~pipe_force_control[0], pipe_action_variant};
        end
        n = 0;
        do begin
            rdy = action_ready;
            @(posedge sys_clk);
            n++;
        end while (!rdy && n < 20);
        action_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("key_go", key_go, 1'b1);
        check("strip_valid", strip_valid, strip_leading_bytes);
        if (strip_leading_bytes) check("strip_count", strip_count, (ptr > 8'h2a) ? 8'h2a : ptr);
        check("frame_pointer", frame_pointer, ptr);
        check("current_layer", current_layer, lay);
        check("clm_done", clm_done, clm);
        check("pipe_forced", pipe_forced, forced);
        if (forced) check("pipe_point", pipe_point, pt);
        if (forced) check("pipe_act", pipe_act, pa);
        check("key_kind", key_kind, kk);
        check("key_dst_info", key_dst_info, following_key_kind == 4'h8);
        if (following_key_kind == 4'h5) check("key_triple", key_triple_indexed, ctrl[lookup_index]);
        rd(8'h04, d);
        check("status", {d[17:16], d[9:0]}, {1'b0, clm, lay, ptr});
        if (strip_leading_bytes) check("last_strip", last_strip, (ptr > 8'h2a) ? 8'h2a : ptr);
        rd(8'h08, d);
        check("error", d[1:0], err);
        if (err != 2'h0) wr(8'h08, {30'h0, err});
        err = 2'h0;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        rst = 1'b1;
        {frame_start, start_pointer, start_layer, vlan_tag_count, ip_version} = '0;
        {ipv4_hdr_words, lookup_index, action_valid, reduced_action, short_pipe_point} = '0;
        {pipe_point_select, pipe_force_control, pipe_action_variant, following_key_kind} = '0;
        {quad_byte_advance, double_byte_advance, layer_skip_code, layer_at_pointer} = '0;
        {strip_leading_bytes, reg_addr, reg_wdata, reg_wr, reg_rd, err, ctrl} = '0;
        {ptr, lay, kk, clm, forced, pt, pa} = '0;
        void'($urandom(58));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(8'h0c, d);
        check("unmapped", d, 32'h0);
        for (int i = 0; i < 80; i++) begin
            if (i % 16 == 0) begin
                ctrl = 3'($urandom);
                wr(8'h00, {29'h0, ctrl});
            end
            if (i % 4 == 0) frame_go();
            act((i < 4) ? 2'(i) : 2'($urandom));
        end
        end_of_test();
    end

    initial begin
        #500000;
        mismatches++;
        end_of_test();
    end
endmodule

`default_nettype wire
